// ==== hdl/hibrtc_core.sv ====
// Hibernation controller: RTC, matches, wake, retained store, interrupts
`timescale 1ns/1ps
module hibrtc_core (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic proc_nrst_in,
  input wire logic osc_raw_in,
  input wire logic xtal_in,
  input wire logic wake_pin_in,
  input wire logic low_batt_in,
  input wire logic module_enable_in,
  input wire logic clock_select_crystal_divided_in,
  input wire logic rtc_enable_in,
  input wire logic rtc_load_in,
  input wire logic [hibrtc_pkg::CNT_W-1:0] rtc_load_value_in,
  input wire logic trim_write_in,
  input wire logic [hibrtc_pkg::TRIM_W-1:0] trim_value_in,
  input wire logic match0_write_in,
  input wire logic match1_write_in,
  input wire logic [hibrtc_pkg::CNT_W-1:0] match_value_in,
  input wire logic wake_on_pin_in,
  input wire logic wake_on_match_in,
  input wire logic lowbat_abort_in,
  input wire logic [hibrtc_pkg::INT_W-1:0] int_enable_in,
  input wire logic [hibrtc_pkg::INT_W-1:0] int_clear_in,
  input wire logic hib_request_in,
  input wire logic mem_write_in,
  input wire logic [hibrtc_pkg::MEM_AW-1:0] mem_addr_in,
  input wire logic [hibrtc_pkg::CNT_W-1:0] mem_wdata_in,
  output logic [hibrtc_pkg::CNT_W-1:0] mem_rdata_out,
  output logic [hibrtc_pkg::CNT_W-1:0] rtc_value_out,
  output logic [hibrtc_pkg::TRIM_W-1:0] trim_out,
  output logic [hibrtc_pkg::CNT_W-1:0] match0_out,
  output logic [hibrtc_pkg::CNT_W-1:0] match1_out,
  output logic [1:0] wake_config_out,
  output logic low_batt_out,
  output logic [hibrtc_pkg::INT_W-1:0] int_raw_out,
  output logic [hibrtc_pkg::INT_W-1:0] int_masked_out,
  output logic irq_out,
  output logic active_out,
  output logic proc_power_en_out
);
  typedef struct packed {
    logic [1:0] wake_s;
    logic [1:0] lb_s;
    logic wake_p;
    logic active;
    logic [hibrtc_pkg::CNT_W-1:0] rtc;
    logic [hibrtc_pkg::TRIM_W-1:0] trim;
    logic [hibrtc_pkg::CNT_W-1:0] m0;
    logic [hibrtc_pkg::CNT_W-1:0] m1;
    logic [hibrtc_pkg::INT_W-1:0] raw;
    logic [hibrtc_pkg::INT_W-1:0] ien;
    logic [1:0] wcfg;
    logic lb_abort;
    logic rtc_en;
    hibrtc_pkg::hibrtc_state_t fsm;
    logic [hibrtc_pkg::CNT_W-1:0] rdata;
  } hibrtc_core_t;
  hibrtc_core_t st_q, st_d;
  logic [hibrtc_pkg::CNT_W-1:0] mem_q [hibrtc_pkg::MEM_WORDS];
  logic [hibrtc_pkg::INT_W-1:0] ev;
  logic m0_hit, m1_hit, wake_edge, wake_now, feat;
  hibrtc_tick_if tk ();
  hibrtc_prescale u_pre (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .osc_raw_in(osc_raw_in),
    .xtal_in(xtal_in),
    .clock_select_crystal_divided_in(clock_select_crystal_divided_in),
    .tk(tk)
  );
  assign tk.trim = st_q.trim;
  assign tk.run = st_q.active && st_q.rtc_en;
  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.wake_s = {st_q.wake_s[0], wake_pin_in};
    st_d.lb_s = {st_q.lb_s[0], low_batt_in};
    st_d.wake_p = st_q.wake_s[1];
    // Processor reset holds this state; core reset, or module_enable_in low outside processor reset, clears it
    st_d.active = module_enable_in || (st_q.active && !proc_nrst_in);
    feat = st_q.active && proc_nrst_in;
    if (!proc_nrst_in && st_q.fsm == hibrtc_pkg::HIBRTC_RUN) feat = 1'b0;
    m0_hit = st_q.active && (st_q.rtc == st_q.m0);
    m1_hit = st_q.active && (st_q.rtc == st_q.m1);
    wake_edge = st_q.wake_s[1] && !st_q.wake_p;
    ev = hibrtc_pkg::INT_NONE;
    ev[hibrtc_pkg::INT_PIN] = st_q.active && wake_edge;
    ev[hibrtc_pkg::INT_LOWBAT] = st_q.active && st_q.lb_s[1];
    ev[hibrtc_pkg::INT_M0] = m0_hit;
    ev[hibrtc_pkg::INT_M1] = m1_hit;
    if (feat) begin
      if (rtc_enable_in != st_q.rtc_en) st_d.rtc_en = rtc_enable_in;
      if (trim_write_in) st_d.trim = trim_value_in;
      if (match0_write_in) st_d.m0 = match_value_in;
      if (match1_write_in) st_d.m1 = match_value_in;
      st_d.wcfg = {wake_on_match_in, wake_on_pin_in};
      st_d.lb_abort = lowbat_abort_in;
      st_d.ien = int_enable_in;
    end
    if (feat && rtc_load_in) st_d.rtc = rtc_load_value_in;
    // Tick is one cycle late; gate with run so a stop is immediate
    else if (tk.tick && tk.run) st_d.rtc = st_q.rtc + 1'b1;
    // Set beats clear so no event is lost
    st_d.raw = (st_q.raw & ~(feat ? int_clear_in : hibrtc_pkg::INT_NONE)) | ev;
    wake_now = (st_q.wcfg[0] && wake_edge) || (st_q.wcfg[1] && (m0_hit || m1_hit));
    case (st_q.fsm)
      hibrtc_pkg::HIBRTC_RUN: begin
        if (feat && hib_request_in && !(st_q.lb_abort && st_q.lb_s[1])) begin
          st_d.fsm = hibrtc_pkg::HIBRTC_POWER_OFF;
        end
      end
      hibrtc_pkg::HIBRTC_POWER_OFF: begin
        if (wake_now) st_d.fsm = hibrtc_pkg::HIBRTC_WAKING;
      end
      hibrtc_pkg::HIBRTC_WAKING: begin
        // Cause stays latched in raw status for software
        st_d.fsm = hibrtc_pkg::HIBRTC_RUN;
      end
      default: st_d.fsm = hibrtc_pkg::HIBRTC_RUN;
    endcase
    if (!st_q.active) begin
      st_d.rtc_en = 1'b0;
      st_d.fsm = hibrtc_pkg::HIBRTC_RUN;
    end
    st_d.rdata = feat ? mem_q[mem_addr_in] : hibrtc_pkg::CNT_ZERO;
  end
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      st_q <= '0;
      st_q.trim <= hibrtc_pkg::TRIM_NOMINAL;
      st_q.fsm <= hibrtc_pkg::HIBRTC_RUN;
    end else begin
      st_q <= st_d;
    end
  end
  // ---------------------------------------------------------------
  // Retained store: no reset, so contents outlive power-off
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (feat && mem_write_in) mem_q[mem_addr_in] <= mem_wdata_in;
  end
  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rtc_value_out = st_q.rtc;
  assign trim_out = st_q.trim;
  assign match0_out = st_q.m0;
  assign match1_out = st_q.m1;
  assign wake_config_out = st_q.wcfg;
  assign low_batt_out = st_q.active && st_q.lb_s[1];
  assign int_raw_out = st_q.raw;
  assign int_masked_out = st_q.raw & st_q.ien;
  assign irq_out = |(st_q.raw & st_q.ien);
  assign active_out = st_q.active;
  assign proc_power_en_out = (st_q.fsm == hibrtc_pkg::HIBRTC_RUN) || (st_q.fsm == hibrtc_pkg::HIBRTC_WAKING);
  assign mem_rdata_out = st_q.rdata;
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_rtc_load;
    @(posedge core_clk_in) disable iff (!nrst_in) (feat && rtc_load_in) |=> (rtc_value_out == $past(rtc_load_value_in));
  endproperty
  a_rtc_load: assert property (p_rtc_load) else $error("rtc load lost");
  property p_rtc_hold;
    @(posedge core_clk_in) disable iff (!nrst_in) (!st_q.rtc_en && !(feat && rtc_load_in)) |=> $stable(rtc_value_out);
  endproperty
  a_rtc_hold: assert property (p_rtc_hold) else $error("rtc moved while stopped");
  property p_match_latch;
    @(posedge core_clk_in) disable iff (!nrst_in) m0_hit |=> int_raw_out[hibrtc_pkg::INT_M0];
  endproperty
  a_match_latch: assert property (p_match_latch) else $error("match0 not latched");
  property p_match1;
    @(posedge core_clk_in) disable iff (!nrst_in) m1_hit |=> int_raw_out[hibrtc_pkg::INT_M1];
  endproperty
  a_match1: assert property (p_match1) else $error("match1 not latched");
  property p_masked;
    @(posedge core_clk_in) disable iff (!nrst_in) (|(ev & st_d.ien)) |=> irq_out;
  endproperty
  a_masked: assert property (p_masked) else $error("irq mismatch");
  property p_lb_abort;
    @(posedge core_clk_in) disable iff (!nrst_in)
      (st_q.fsm == hibrtc_pkg::HIBRTC_RUN && st_q.lb_abort && st_q.lb_s[1]) |=> proc_power_en_out;
  endproperty
  a_lb_abort: assert property (p_lb_abort) else $error("hibernation not aborted");
  property p_wake;
    @(posedge core_clk_in) disable iff (!nrst_in)
      (st_q.fsm == hibrtc_pkg::HIBRTC_POWER_OFF && wake_now && st_q.active) |=> ##1 proc_power_en_out;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not restore power");
  property p_cause_kept;
    @(posedge core_clk_in) disable iff (!nrst_in)
      (int_raw_out[hibrtc_pkg::INT_PIN] && !feat) |=> int_raw_out[hibrtc_pkg::INT_PIN];
  endproperty
  a_cause_kept: assert property (p_cause_kept) else $error("wake cause lost");
  property p_disabled;
    @(posedge core_clk_in) disable iff (!nrst_in) !active_out |=> (mem_rdata_out == hibrtc_pkg::CNT_ZERO);
  endproperty
  a_disabled: assert property (p_disabled) else $error("feature live while disabled");
  c_hib: cover property (@(posedge core_clk_in) disable iff (!nrst_in) st_q.fsm == hibrtc_pkg::HIBRTC_POWER_OFF);
  c_wake: cover property (@(posedge core_clk_in) disable iff (!nrst_in) st_q.fsm == hibrtc_pkg::HIBRTC_WAKING);
  c_match: cover property (@(posedge core_clk_in) disable iff (!nrst_in) m0_hit && st_q.ien[hibrtc_pkg::INT_M0]);
endmodule : hibrtc_core

// ==== shared/hibrtc_pkg.sv ====
// Package with constants and types for the hibernation RTC wake controller
package hibrtc_pkg;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned MEM_WORDS = 64;
  localparam int unsigned MEM_AW = 6;
  localparam int unsigned TRIM_W = 16;
  localparam int unsigned DIV_W = 7;
  // ---------------------------------------------------------------
  // Interrupt bit positions
  // ---------------------------------------------------------------
  localparam int unsigned INT_W = 4;
  localparam int unsigned INT_PIN = 0;
  localparam int unsigned INT_LOWBAT = 1;
  localparam int unsigned INT_M0 = 2;
  localparam int unsigned INT_M1 = 3;
  // ---------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------
  localparam logic [TRIM_W-1:0] TRIM_NOMINAL = 16'h7fff;
  localparam logic [DIV_W-1:0] DIV128_LAST = 7'h7f;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [TRIM_W-1:0] TRIM_ZERO = 16'h0000;
  localparam logic [INT_W-1:0] INT_NONE = 4'h0;
  typedef enum logic [1:0] {HIBRTC_RUN, HIBRTC_POWER_OFF, HIBRTC_WAKING} hibrtc_state_t;
endpackage : hibrtc_pkg

// ==== shared/hibrtc_tick_if.sv ====
// Interface carrying the seconds tick between prescaler and core
`timescale 1ns/1ps
interface hibrtc_tick_if;
  logic tick;
  logic [hibrtc_pkg::TRIM_W-1:0] trim;
  logic run;
  modport src (output tick, input trim, input run);
  modport dst (input tick, output trim, output run);
endinterface : hibrtc_tick_if

// ==== hdl/hibrtc_prescale.sv ====
// Clock-source selection and trimmed seconds prescaler
`timescale 1ns/1ps
module hibrtc_prescale (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic osc_raw_in,
  input wire logic xtal_in,
  input wire logic clock_select_crystal_divided_in,
  hibrtc_tick_if.src tk
);
  typedef struct packed {
    logic [1:0] osc_s;
    logic [1:0] xtal_s;
    logic osc_p;
    logic xtal_p;
    logic [hibrtc_pkg::DIV_W-1:0] div;
    logic [hibrtc_pkg::TRIM_W-1:0] sub;
    logic tick;
  } hibrtc_pre_t;
  hibrtc_pre_t st_q, st_d;
  logic edge_en;
  always_comb begin
    st_d = st_q;
    st_d.osc_s = {st_q.osc_s[0], osc_raw_in};
    st_d.xtal_s = {st_q.xtal_s[0], xtal_in};
    st_d.osc_p = st_q.osc_s[1];
    st_d.xtal_p = st_q.xtal_s[1];
    edge_en = 1'b0;
    st_d.tick = 1'b0;
    // ---------------------------------------------------------------
    // Source select: raw oscillator or crystal over 128
    // ---------------------------------------------------------------
    if (clock_select_crystal_divided_in) begin
      if (st_q.xtal_s[1] && !st_q.xtal_p) begin
        st_d.div = st_q.div + 1'b1;
        edge_en = (st_q.div == hibrtc_pkg::DIV128_LAST);
      end
    end else begin
      edge_en = st_q.osc_s[1] && !st_q.osc_p;
    end
    // Trim sets the sub-second terminal count
    if (tk.run && edge_en) begin
      if (st_q.sub >= tk.trim) begin
        st_d.sub = hibrtc_pkg::TRIM_ZERO;
        st_d.tick = 1'b1;
      end else begin
        st_d.sub = st_q.sub + 1'b1;
      end
    end
    if (!tk.run) st_d.sub = hibrtc_pkg::TRIM_ZERO;
  end
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) st_q <= '0;
    else st_q <= st_d;
  end
  assign tk.tick = st_q.tick;
  property p_tick_needs_run;
    @(posedge core_clk_in) disable iff (!nrst_in) st_q.tick |-> $past(tk.run);
  endproperty
  a_tick_needs_run: assert property (p_tick_needs_run) else $error("tick without run");
endmodule : hibrtc_prescale

// ==== verif/hibrtc_far_model.sv ====
// Wake pin and backup supply model facing the hibernation controller
`timescale 1ns/1ps
module hibrtc_far_model (
  input wire logic wake_req_in,
  input wire logic batt_low_req_in,
  output logic wake_pin_out,
  output logic low_batt_out,
  output logic osc_raw_out,
  output logic xtal_out
);
  // ---------------------------------------------------------------
  // Clock sources
  // ---------------------------------------------------------------
  // Both sources are far faster than real parts to keep runs short
  initial osc_raw_out = 1'b0;
  always #40 osc_raw_out = ~osc_raw_out;
  initial xtal_out = 1'b0;
  always #10 xtal_out = ~xtal_out;
  // ---------------------------------------------------------------
  // Wake pin and battery level
  // ---------------------------------------------------------------
  // Pin idles low; a request gives one high pulse off the clock grid
  initial wake_pin_out = 1'b0;
  always @(posedge wake_req_in) begin
    #3 wake_pin_out = 1'b1;
    #400 wake_pin_out = 1'b0;
  end
  assign low_batt_out = batt_low_req_in;
endmodule : hibrtc_far_model

// ==== verif/hibrtc_tb_top.sv ====
// Self-checking testbench for the hibernation controller core
`timescale 1ns/1ps
module hibrtc_tb_top;
  logic core_clk_in, nrst_in, proc_nrst_in, module_enable_in, clock_select_crystal_divided_in;
  logic rtc_enable_in, rtc_load_in, trim_write_in, match0_write_in, match1_write_in;
  logic wake_on_pin_in, wake_on_match_in, lowbat_abort_in, hib_request_in, mem_write_in;
  logic [31:0] rtc_load_value_in, match_value_in, mem_wdata_in, mem_rdata_out, rtc_value_out;
  logic [31:0] match0_out, match1_out, r, base;
  logic [15:0] trim_value_in, trim_out, seed;
  logic [5:0] mem_addr_in;
  logic [3:0] int_enable_in, int_clear_in, int_raw_out, int_masked_out;
  logic [1:0] wake_config_out;
  logic low_batt_out, irq_out, active_out, proc_power_en_out, wake_req, batt_low_req;
  logic osc_raw_in, xtal_in, wake_pin_in, low_batt_in;
  logic [35:0] notes[$];
  int miscompares, n_tests;
  hibrtc_core u_hibrtc_core (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .proc_nrst_in(proc_nrst_in),
    .osc_raw_in(osc_raw_in), .xtal_in(xtal_in), .wake_pin_in(wake_pin_in), .low_batt_in(low_batt_in),
    .module_enable_in(module_enable_in), .clock_select_crystal_divided_in(clock_select_crystal_divided_in),
    .rtc_enable_in(rtc_enable_in), .rtc_load_in(rtc_load_in), .rtc_load_value_in(rtc_load_value_in),
    .trim_write_in(trim_write_in), .trim_value_in(trim_value_in), .match0_write_in(match0_write_in),
    .match1_write_in(match1_write_in), .match_value_in(match_value_in), .wake_on_pin_in(wake_on_pin_in),
    .wake_on_match_in(wake_on_match_in), .lowbat_abort_in(lowbat_abort_in), .int_enable_in(int_enable_in),
    .int_clear_in(int_clear_in), .hib_request_in(hib_request_in), .mem_write_in(mem_write_in),
    .mem_addr_in(mem_addr_in), .mem_wdata_in(mem_wdata_in), .mem_rdata_out(mem_rdata_out),
    .rtc_value_out(rtc_value_out), .trim_out(trim_out), .match0_out(match0_out), .match1_out(match1_out),
    .wake_config_out(wake_config_out), .low_batt_out(low_batt_out), .int_raw_out(int_raw_out),
    .int_masked_out(int_masked_out), .irq_out(irq_out), .active_out(active_out),
    .proc_power_en_out(proc_power_en_out));
  hibrtc_far_model u_hibrtc_far_model (.wake_req_in(wake_req), .batt_low_req_in(batt_low_req),
    .wake_pin_out(wake_pin_in), .low_batt_out(low_batt_in), .osc_raw_out(osc_raw_in), .xtal_out(xtal_in));
  always #4 core_clk_in = ~core_clk_in;
  // ---------------------------------------------------------------
  // Checking
  // ---------------------------------------------------------------
  function automatic logic [31:0] obs(input logic [3:0] s);
    case (s)
      0: return rtc_value_out;
      1: return {16'h0000, trim_out};
      2: return match0_out;
      3: return match1_out;
      4: return {30'h0000_0000, wake_config_out};
      5: return {31'h0000_0000, low_batt_out};
      6: return {28'h000_0000, int_raw_out};
      7: return {28'h000_0000, int_masked_out};
      8: return {31'h0000_0000, irq_out};
      9: return {31'h0000_0000, active_out};
      10: return {31'h0000_0000, proc_power_en_out};
      11: return mem_rdata_out;
      default: return {31'h0000_0000, rtc_value_out >= 32'h0000_0001 && rtc_value_out <= 32'h0000_0004};
    endcase
  endfunction : obs
  task compare(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : compare
  task note(input logic [3:0] s, input logic [31:0] v);
    notes.push_back({s, v});
  endtask : note
  always @(negedge core_clk_in) begin
    while (notes.size() > 0) begin
      compare(obs(notes[0][35:32]), notes[0][31:0]);
      void'(notes.pop_front());
    end
  end
  task results;
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  // ---------------------------------------------------------------
  // Drivers
  // ---------------------------------------------------------------
  task cyc(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask : cyc
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task rnd;
    seed = lfsr(seed);
    r = {seed, ~seed[7:0], seed[15:8]};
  endtask : rnd
  task wr(input int k, input logic [31:0] v);
    {rtc_load_in, trim_write_in, match0_write_in, match1_write_in, mem_write_in} <= 5'h10 >> k;
    {rtc_load_value_in, match_value_in, mem_wdata_in, trim_value_in} <= {v, v, v, v[15:0]};
    cyc(1);
    {rtc_load_in, trim_write_in, match0_write_in, match1_write_in, mem_write_in} <= 5'h00;
    cyc(2);
  endtask : wr
  task pulse_clr(input logic [3:0] m);
    int_clear_in <= m;
    cyc(1);
    int_clear_in <= 4'h0;
    cyc(2);
  endtask : pulse_clr
  task hib;
    hib_request_in <= 1'b1;
    cyc(1);
    hib_request_in <= 1'b0;
    cyc(3);
  endtask : hib
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    {core_clk_in, nrst_in, proc_nrst_in, module_enable_in, clock_select_crystal_divided_in} = '0;
    {rtc_enable_in, rtc_load_in, trim_write_in, match0_write_in, match1_write_in, mem_write_in} = '0;
    {wake_on_pin_in, wake_on_match_in, lowbat_abort_in, hib_request_in, wake_req, batt_low_req} = '0;
    {rtc_load_value_in, match_value_in, mem_wdata_in, trim_value_in, mem_addr_in} = '0;
    {int_enable_in, int_clear_in, miscompares, n_tests} = '0;
    seed = 16'hac76;
    cyc(8);
    {nrst_in, proc_nrst_in} <= 2'b11;
    cyc(2);
    note(10, 1);
    note(1, 32'h0000_7fff);
    wr(0, 32'h1234_5678);
    note(0, 0);
    note(9, 0);
    module_enable_in <= 1'b1;
    cyc(2);
    note(9, 1);
    rnd;
    wr(1, r); // Oscillator source needs no settle wait
    note(1, r[15:0]);
    rnd;
    base = r;
    wr(2, base + 2);
    wr(3, base + 4);
    note(2, base + 2);
    note(3, base + 4);
    for (int i = 0; i < 4; i++) begin
      {wake_on_match_in, wake_on_pin_in} <= i[1:0];
      cyc(2);
      note(4, i);
    end
    for (int i = 0; i < 6; i++) begin
      rnd;
      mem_addr_in <= (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : r[5:0];
      wr(4, r);
      note(11, r);
    end
    wr(0, base);
    cyc(200);
    note(0, base); // Counter held while its enable is low
    pulse_clr(4'hc); // Drop hits left from equal values at start
    note(6, 0);
    wr(1, 3);
    rtc_enable_in <= 1'b1;
    cyc(300);
    rtc_enable_in <= 1'b0;
    cyc(3);
    note(6, 4'hc);
    note(7, 0);
    int_enable_in <= 4'h4;
    cyc(2);
    note(7, 4'h4);
    note(8, 1);
    pulse_clr(4'hc);
    note(6, 0);
    note(8, 0);
    batt_low_req <= 1'b1;
    lowbat_abort_in <= 1'b1;
    cyc(6);
    note(5, 1);
    note(6, 4'h2);
    hib;
    note(10, 1); // Request dropped on low battery
    batt_low_req <= 1'b0;
    {wake_on_match_in, wake_on_pin_in} <= 2'b01;
    cyc(6);
    int_enable_in <= 4'h5;
    pulse_clr(4'h2);
    hib;
    note(10, 0);
    proc_nrst_in <= 1'b0;
    wake_req <= 1'b1;
    cyc(20);
    note(10, 1);
    note(6, 4'h1);
    note(7, 4'h1);
    note(8, 1);
    note(9, 1);
    proc_nrst_in <= 1'b1;
    cyc(2);
    note(11, r); // Last stored word survives power off
    clock_select_crystal_divided_in <= 1'b1;
    wr(1, 1);
    wr(0, 0);
    rtc_enable_in <= 1'b1;
    cyc(1500);
    note(12, 1); // Slow divided crystal gives only a few ticks
    cyc(3);
    results();
  end
  initial begin
    repeat (20000) @(posedge core_clk_in);
    miscompares++;
    results();
  end
endmodule : hibrtc_tb_top
